/* File: shared/twi_pkg.sv */
// package: register map, fields, divider table and shared types
package twi_pkg;
	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	// own address format sits at word index 0x19d: its byte address is four times the index
	localparam logic [11:0] idx_own_address_format  = 12'h19d;
	localparam logic [11:0] addr_own_address_format = {idx_own_address_format[9:0], 2'b00};
	localparam logic [11:0] addr_ctrl      = 12'h1a0;
	localparam logic [11:0] addr_tx_buffer = 12'h1a4;
	localparam logic [11:0] addr_rx_buffer = 12'h1a8;
	localparam logic [11:0] addr_status    = 12'h1ac;
	localparam logic [11:0] addr_mask      = 12'h1b0;
	// ------------------------------------------------------------
	// fields
	// ------------------------------------------------------------
	localparam int          fs_bit        = 0;
	localparam int          sva_lsb       = 1;
	localparam logic [7:0]  oaf_reset     = 8'h00;
	localparam int          st_tx_empty   = 0;
	localparam int          st_rx_full    = 1;
	localparam int          st_addr_match = 2;
	localparam int          st_width      = 3;
	// ------------------------------------------------------------
	// divider table, f1 cycles per bus clock period
	// ------------------------------------------------------------
	localparam logic [9:0] div_table [16] = '{
		10'h01c, 10'h028, 10'h030, 10'h040, 10'h050, 10'h064, 10'h070, 10'h080,
		10'h038, 10'h050, 10'h060, 10'h080, 10'h0a0, 10'h0c8, 10'h0e0, 10'h100};
	localparam int clk_mhz = 200;

	typedef struct packed {
		logic       master_select;
		logic       transmit;
		logic       rate_double_bit;
		logic       rate_half_bit;
		logic [3:0] divider_code;
	} ctrl_t;

	typedef struct packed {
		logic i;
		logic o;
		logic oe;
	} pin_t;
endpackage

/* File: verif/test_twi_addr_shift_clock.sv */
// testbench: registers, master clock rates, transmit and slave receive
`timescale 1ns/1ps
module test_twi_addr_shift_clock;
	import twi_pkg::*;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        scl_o, scl_oe, sda_o, sda_oe, irq, scl_drv, sda_drv, scl_line, sda_line;
	int          err_total = 0;
	int          cmp_count = 0;
	// wired-and with pull-ups
	assign scl_line = scl_drv & ~scl_oe;
	assign sda_line = sda_drv & ~sda_oe;
	twi_addr_shift_clock dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_line),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
	twi_bus_model bus_u (.pclk(pclk), .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		do_reset();
		apb(1'b0, addr_own_address_format, 32'h0, r, e);
		check("own address reset", 32'h0, r);
		apb(1'b1, addr_own_address_format, 32'h1ab, r, e);
		apb(1'b0, addr_own_address_format, 32'h0, r, e);
		check("own address", 32'hab, r);
		apb(1'b0, 12'h1b4, 32'h0, r, e);
		check("unmapped error", 32'h1, {31'h0, e});
		check("unmapped data", 32'h0, r);
		$display("test regs done");
	endtask
	// doubling and halving never both set
	task automatic t_rate(input logic [3:0] c, input logic d, input logic h, input int exp);
		logic [31:0] r;
		logic        e, p;
		logic [7:0]  b;
		ctrl_t       cv;
		int          k, n, t1, per;
		do_reset();
		cv = '{1'b1, 1'b1, d, h, c};
		apb(1'b1, addr_ctrl, {24'h0, cv}, r, e);
		apb(1'b1, addr_tx_buffer, 32'ha5, r, e);
		k = 0;
		n = 0;
		t1 = 0;
		per = 0;
		p = scl_line;
		while (k < 8 && n < 30000) begin
			@(posedge pclk);
			n++;
			if (scl_line && !p) begin
				b[7-k] = sda_line;
				if (k == 1) t1 = n;
				if (k == 2) per = n - t1;
				k++;
			end
			p = scl_line;
		end
		check("scl period", 32'(exp), 32'(per));
		check("sent byte", 32'ha5, {24'h0, b});
		apb(1'b0, addr_status, 32'h0, r, e);
		check("tx empty", 32'h1, {31'h0, r[st_tx_empty]});
		$display("test rate code %h done", c);
	endtask
	task automatic t_slave(input logic [7:0] oaf, input logic [6:0] a, input logic m);
		logic [31:0] r;
		logic        e, ack;
		do_reset();
		apb(1'b1, addr_own_address_format, {24'h0, oaf}, r, e);
		apb(1'b1, addr_mask, 32'h7, r, e);
		bus_u.start_frame();
		bus_u.send_byte({a, 1'b0}, ack);
		check("addr ack", {31'h0, m}, {31'h0, ack});
		apb(1'b0, addr_status, 32'h0, r, e);
		check("addr match", {31'h0, m}, {31'h0, r[st_addr_match]});
		if (m) begin
			bus_u.send_byte(8'h3c, ack);
			apb(1'b0, addr_rx_buffer, 32'h0, r, e);
			check("rx byte", 32'h3c, r);
			apb(1'b0, addr_status, 32'h0, r, e);
			check("rx full", 32'h1, {31'h0, r[st_rx_full]});
			check("irq set", 32'h1, {31'h0, irq});
			apb(1'b1, addr_mask, 32'h0, r, e);
			@(posedge pclk);
			check("irq masked", 32'h0, {31'h0, irq});
			apb(1'b1, addr_status, 32'h7, r, e);
			apb(1'b1, addr_mask, 32'h7, r, e);
			apb(1'b0, addr_status, 32'h0, r, e);
			check("status cleared", 32'h0, r & 32'h6);
			check("irq cleared", 32'h0, {31'h0, irq});
		end
		bus_u.stop_frame();
		$display("test slave %h done", oaf);
	endtask
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		t_regs();
		t_rate(4'h0, 1'b0, 1'b0, 28);
		t_rate(4'h7, 1'b0, 1'b0, 128);
		t_rate(4'h8, 1'b0, 1'b0, 56);
		t_rate(4'hf, 1'b0, 1'b0, 256);
		t_rate(4'h0, 1'b1, 1'b0, 14);
		t_rate(4'h0, 1'b0, 1'b1, 56);
		t_slave(8'hb4, 7'h5a, 1'b1);
		t_slave(8'hb4, 7'h11, 1'b0);
		t_slave(8'hb5, 7'h5a, 1'b0);
		give_verdict();
	end
	initial begin
		#300us;
		err_total++;
		give_verdict();
	end
endmodule

/* File: verif/twi_asc_assertions.sv */
// checker: port-level properties of the address, shift and clock block
`timescale 1ns/1ps
module twi_asc_assertions
	import twi_pkg::*;
(
	// apb side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins and interrupt
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_o,
	input wire logic        irq
);
	// ------------------------------------------------------------
	// shadow of written settings
	// ------------------------------------------------------------
	logic       acc;
	logic       mapped;
	logic       master_q;
	logic [7:0] oaf_q;
	logic [2:0] mask_q;
	assign acc = psel & penable;
	assign mapped = paddr inside {addr_own_address_format, addr_ctrl, addr_tx_buffer, addr_rx_buffer,
		addr_status, addr_mask};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_q <= 1'b0;
			oaf_q    <= 8'h00;
			mask_q   <= 3'h0;
		end else if (acc && pwrite) begin
			if (paddr == addr_ctrl) master_q <= pwdata[7];
			if (paddr == addr_own_address_format) oaf_q <= pwdata[7:0];
			if (paddr == addr_mask) mask_q <= pwdata[2:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_read(logic [11:0] a);
		acc && !pwrite && paddr == a;
	endsequence
	chk_ready_always: assert property (pready) else $error("pready low");
	chk_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
	chk_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("error on mapped");
	chk_prdata_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0) else $error("prdata not 0");
	chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
	chk_addr_readback: assert property (s_read(addr_own_address_format) |-> prdata[7:0] == oaf_q)
		else $error("own address readback wrong");
	chk_slave_noclock: assert property (!master_q && !$past(master_q) |-> !scl_oe)
		else $error("clock driven in slave mode");
	chk_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq) else $error("irq while masked");
	chk_pins_low: assert property (!scl_o && !sda_o)
		else $error("pin output not low");
endmodule
bind twi_addr_shift_clock twi_asc_assertions chk_u (
	.pclk    (pclk),
	.presetn (presetn),
	.psel    (psel),
	.penable (penable),
	.pwrite  (pwrite),
	.paddr   (paddr),
	.pwdata  (pwdata),
	.prdata  (prdata),
	.pready  (pready),
	.pslverr (pslverr),
	.scl_o   (scl_o),
	.scl_oe  (scl_oe),
	.sda_o   (sda_o),
	.irq     (irq)
);

/* File: verif/twi_bus_model.sv */
// partner: remote master framing bytes on the open-drain lines
`timescale 1ns/1ps
module twi_bus_model (
	// pacing clock
	input  wire logic pclk,
	// lines, released high by pull-ups
	input  wire logic sda_line,
	output logic      scl_drv,
	output logic      sda_drv
);
	// clock stands high between frames
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic hold();
		repeat (12) @(posedge pclk);
	endtask
	// start: data falls while clock high
	task automatic start_frame();
		sda_drv <= 1'b0;
		hold();
		scl_drv <= 1'b0;
		hold();
	endtask
	// msb first, data released in the ninth slot for the ack
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_drv <= (i > 0) ? b[i-1] : 1'b1;
			hold();
			scl_drv <= 1'b1;
			hold();
			if (i == 0) ack = !sda_line;
			scl_drv <= 1'b0;
			hold();
		end
	endtask
	task automatic stop_frame();
		sda_drv <= 1'b0;
		hold();
		scl_drv <= 1'b1;
		hold();
		sda_drv <= 1'b1;
		hold();
	endtask
endmodule

/* File: verilog/byte_shifter.sv */
// eight bit shift register, msb first
`timescale 1ns/1ps
module byte_shifter (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	input  wire logic       shift,
	input  wire logic       sin,
	// state
	output logic [7:0]      byte_shift_register,
	output logic            sout
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			byte_shift_register <= 8'h00;
		else if (load)
			byte_shift_register <= load_data;
		else if (shift)
			byte_shift_register <= {byte_shift_register[6:0], sin};
	end
	assign sout = byte_shift_register[7];
endmodule

/* File: verilog/rate_gen.sv */
// transfer clock divider with rate modifiers
`timescale 1ns/1ps
module rate_gen (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// setting
	input  wire logic       run,
	input  wire logic [3:0] divider_code,
	input  wire logic       rate_double_bit,
	input  wire logic       rate_half_bit,
	// output
	output logic            scl_int,
	output logic            rise_pulse,
	output logic            fall_pulse
);
	import twi_pkg::*;
	logic [10:0] period;
	logic [10:0] cnt_reg;
	logic [10:0] half;

	always_comb begin
		// RULE_09 RULE_10: table divisor
		period = {1'b0, div_table[divider_code]};
		// RULE_11: double rate
		if (rate_double_bit && !rate_half_bit)
			period = {2'b00, div_table[divider_code][9:1]};
		// RULE_12: half rate
		else if (rate_half_bit && !rate_double_bit)
			period = {div_table[divider_code], 1'b0};
		half = {1'b0, period[10:1]};
	end

	// RULE_17: reload per period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_reg <= 11'h000;
		else if (!run || cnt_reg >= period - 11'h001)
			cnt_reg <= 11'h000;
		else
			cnt_reg <= cnt_reg + 11'h001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			scl_int <= 1'b1;
		else if (!run)
			scl_int <= 1'b1;
		else if (cnt_reg == 11'h000)
			scl_int <= 1'b0;
		else if (cnt_reg == half)
			scl_int <= 1'b1;
	end

	assign fall_pulse = run && cnt_reg == 11'h000 && scl_int;
	assign rise_pulse = run && cnt_reg == half && !scl_int;
endmodule

/* File: verilog/twi_addr_shift_clock.sv */
// own address, byte shifting and transfer clock of the two-wire unit
//
// Notes on behaviour
// RULE_01: framing select 0 is two-wire framing, 1 is clocked synchronous serial.
// RULE_02: own 7-bit address sits in bits 7..1, msb at bit 7.
// RULE_03: slave, two-wire: first frame upper seven bits matching address selects us.
// RULE_04: software picks an address no other slave on the bus uses.
// RULE_05: transmit loads tx buffer into shift register, shifts out on data line.
// RULE_06: receive copies shift register to rx buffer after a full byte.
// RULE_07: master select 0: clock taken from clock line, never driven.
// RULE_08: master select 1: clock made internally and driven on clock line.
// RULE_09: normal codes 0..7 divide f1 by 28,40,48,64,80,100,112,128.
// RULE_10: top code bit set divides by 56,80,96,128,160,200,224,256.
// RULE_11: doubling bit alone doubles the transfer rate.
// RULE_12: halving bit alone halves the transfer rate.
// RULE_13: tx empty flag sets when buffer moves into shift register.
// RULE_14: rx full flag sets when received byte moves into rx buffer.
// RULE_15: address match flag sets on matching first frame in slave receive.
// RULE_16: software never sets doubling and halving bits together.
// RULE_17: divider counter reloads each divisor count, one bus period each.
`timescale 1ns/1ps
module twi_addr_shift_clock (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial pins
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// interrupt
	output logic             irq
);
	import twi_pkg::*;

	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_bits  = 2'b01,
		st_ack   = 2'b10
	} phase_t;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]          own_address_format_reg;
	ctrl_t               ctrl_reg;
	logic [7:0]          tx_buffer_reg;
	logic                tx_full_reg;
	logic [7:0]          rx_buffer_reg;
	logic [st_width-1:0] status_reg;
	logic [st_width-1:0] mask_reg;
	logic [31:0]         rd_next;
	logic                wr;
	logic                rd;
	logic                hit;

	assign wr      = psel && penable && pwrite;
	assign rd      = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign hit     = paddr == addr_own_address_format || paddr == addr_ctrl || paddr == addr_tx_buffer ||
	                 paddr == addr_rx_buffer || paddr == addr_status || paddr == addr_mask;
	assign pslverr = psel && penable && !hit;

	// ------------------------------------------------------------
	// serial clock source
	// ------------------------------------------------------------
	logic scl_int;
	logic int_rise;
	logic int_fall;
	logic scl_q_reg;
	logic scl_rise;
	logic scl_fall;
	logic framing_select;
	logic [6:0] own_slave_addr_bits;
	phase_t phase_reg;

	// RULE_01: framing bit
	assign framing_select      = own_address_format_reg[fs_bit];
	// RULE_02: address field
	assign own_slave_addr_bits = own_address_format_reg[7:sva_lsb];

	rate_gen u_rate (
		.pclk            (pclk),
		.presetn         (presetn),
		.run             (ctrl_reg.master_select && phase_reg != st_idle),
		.divider_code    (ctrl_reg.divider_code),
		.rate_double_bit (ctrl_reg.rate_double_bit),
		.rate_half_bit   (ctrl_reg.rate_half_bit),
		.scl_int         (scl_int),
		.rise_pulse      (int_rise),
		.fall_pulse      (int_fall)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			scl_q_reg <= 1'b1;
		else
			scl_q_reg <= scl_i;
	end

	// RULE_07: slave follows line
	// RULE_08: master uses divider and drives
	assign scl_rise = ctrl_reg.master_select ? int_rise : (scl_i && !scl_q_reg);
	assign scl_fall = ctrl_reg.master_select ? int_fall : (!scl_i && scl_q_reg);
	assign scl_o    = 1'b0;
	assign scl_oe   = ctrl_reg.master_select && !scl_int;

	// ------------------------------------------------------------
	// start detection, two-wire framing only
	// ------------------------------------------------------------
	logic sda_q_reg;
	logic start_det;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sda_q_reg <= 1'b1;
		else
			sda_q_reg <= sda_i;
	end
	assign start_det = !framing_select && scl_i && scl_q_reg && sda_q_reg && !sda_i;

	// ------------------------------------------------------------
	// byte sequencing
	// ------------------------------------------------------------
	logic [3:0] bit_cnt_reg;
	logic       first_frame_reg;
	logic       load_sr;
	logic       byte_done;
	logic [7:0] sr;
	logic       sr_out;
	logic       sda_drive_reg;
	logic       addressed_reg;

	// RULE_05: load tx buffer when starting a transmit byte
	assign load_sr   = ctrl_reg.transmit && tx_full_reg && phase_reg == st_idle &&
	                   (ctrl_reg.master_select || scl_fall);
	assign byte_done = phase_reg == st_bits && scl_rise && bit_cnt_reg == 4'h7;

	byte_shifter u_shift (
		.pclk                (pclk),
		.presetn             (presetn),
		.load                (load_sr),
		.load_data           (tx_buffer_reg),
		.shift               (phase_reg == st_bits && scl_rise),
		.sin                 (sda_i),
		.byte_shift_register (sr),
		.sout                (sr_out)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg   <= st_idle;
			bit_cnt_reg <= 4'h0;
		end else if (start_det) begin
			phase_reg   <= st_bits;
			bit_cnt_reg <= 4'h0;
		end else begin
			case (phase_reg)
			st_idle: begin
				bit_cnt_reg <= 4'h0;
				if (load_sr || (!ctrl_reg.transmit && !ctrl_reg.master_select && scl_fall))
					phase_reg <= st_bits;
			end
			st_bits: begin
				if (scl_rise)
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (byte_done)
					phase_reg <= framing_select ? st_idle : st_ack;
			end
			st_ack: begin
				if (scl_rise)
					phase_reg <= st_idle;
			end
			default: phase_reg <= st_idle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			first_frame_reg <= 1'b0;
		else if (start_det)
			first_frame_reg <= 1'b1;
		else if (byte_done)
			first_frame_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// data line drive
	// ------------------------------------------------------------
	// data driven low only, and changed only while the clock is low:
	// a change with the clock high would read as a start or stop on the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sda_drive_reg <= 1'b0;
		// RULE_05: slave first bit from buffer
		else if (load_sr && !ctrl_reg.master_select)
			sda_drive_reg <= !tx_buffer_reg[7];
		else if (scl_fall) begin
			if (phase_reg == st_bits && ctrl_reg.transmit)
				sda_drive_reg <= !sr_out;
			// RULE_03: addressed slave acknowledges
			else if (phase_reg == st_ack && addressed_reg && !ctrl_reg.transmit)
				sda_drive_reg <= 1'b1;
			else
				sda_drive_reg <= 1'b0;
		end
	end
	assign sda_o  = 1'b0;
	assign sda_oe = sda_drive_reg;

	// ------------------------------------------------------------
	// events
	// ------------------------------------------------------------
	logic               addr_match;
	logic               rx_store;
	logic [st_width-1:0] ev;
	// RULE_03: compare upper seven bits
	assign addr_match = byte_done && first_frame_reg && !framing_select && !ctrl_reg.master_select &&
	                    !ctrl_reg.transmit && sr[6:0] == own_slave_addr_bits;
	// RULE_06: full byte to rx buffer
	assign rx_store   = byte_done && !ctrl_reg.transmit;

	// selected until the next start on the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			addressed_reg <= 1'b0;
		else if (start_det)
			addressed_reg <= 1'b0;
		else if (addr_match)
			addressed_reg <= 1'b1;
	end

	always_comb begin
		ev = '0;
		// RULE_13: tx empty on load
		ev[st_tx_empty]   = load_sr;
		// RULE_14: rx full on store
		ev[st_rx_full]    = rx_store;
		// RULE_15: address match
		ev[st_addr_match] = addr_match;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_buffer_reg <= 8'h00;
		else if (rx_store)
			rx_buffer_reg <= {sr[6:0], sda_i};
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_address_format_reg <= oaf_reset;
			ctrl_reg               <= '0;
			mask_reg               <= '0;
		end else if (wr) begin
			if (paddr == addr_own_address_format)
				own_address_format_reg <= pwdata[7:0];
			if (paddr == addr_ctrl)
				ctrl_reg <= pwdata[7:0];
			if (paddr == addr_mask)
				mask_reg <= pwdata[st_width-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buffer_reg <= 8'h00;
			tx_full_reg   <= 1'b0;
		end else if (wr && paddr == addr_tx_buffer) begin
			tx_buffer_reg <= pwdata[7:0];
			tx_full_reg   <= 1'b1;
		end else if (load_sr)
			tx_full_reg <= 1'b0;
	end

	// set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_reg <= '0;
		else if (wr && paddr == addr_status)
			status_reg <= (status_reg & ~pwdata[st_width-1:0]) | ev;
		else
			status_reg <= status_reg | ev;
	end

	assign irq = |(status_reg & mask_reg);

	always_comb begin
		rd_next = 32'h0000_0000;
		case (paddr)
		addr_own_address_format: rd_next[7:0] = own_address_format_reg;
		addr_ctrl:               rd_next[7:0] = ctrl_reg;
		addr_tx_buffer:          rd_next[7:0] = tx_buffer_reg;
		addr_rx_buffer:          rd_next[7:0] = rx_buffer_reg;
		addr_status:             rd_next[st_width-1:0] = status_reg;
		addr_mask:               rd_next[st_width-1:0] = mask_reg;
		default:                 rd_next = 32'h0000_0000;
		endcase
	end

	// read data only valid in access phase
	assign prdata = rd ? rd_next : 32'h0000_0000;
endmodule
